// file: design/blcfr_i2c_slave.sv
// Purpose: serial two-wire register slave with address pointer
// Assumes: link pins are asynchronous, sampled by clk_in
// Notes:   first written byte sets the pointer; pointer auto-increments
`timescale 1ns/10ps
module blcfr_i2c_slave
   import blcfr_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [7:0] rd_data_in,
   output logic            sda_oe_out,
   output logic            wr_stb_out,
   output logic [7:0]      wr_addr_out,
   output logic [7:0]      wr_data_out,
   output logic            rd_stb_out,
   output logic [7:0]      rd_addr_out
);
   logic [2:0]   scl_q;
   logic [2:0]   sda_q;
   blcfr_state_t state;
   logic [3:0]   bit_cnt;
   logic [7:0]   shreg;
   logic [7:0]   ptr;
   logic         first;
   logic         rw;

   // stage 0 feeds only stage 1; edges look at stages 1 and 2
   wire scl_rise  = scl_q[1] & ~scl_q[2];
   wire scl_fall  = ~scl_q[1] & scl_q[2];
   wire start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   wire stop_det  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   wire byte_done = (bit_cnt == BITS_PER_BYTE);
   wire addr_hit  = (shreg[7:1] == DEV_ADDR);
   wire load_now  = scl_fall & ((state == ST_ADDR_ACK & rw)
                                | state == ST_RACK);

   assign rd_stb_out  = load_now;
   assign rd_addr_out = ptr;

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], scl_in};
         sda_q <= {sda_q[1:0], sda_in};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         state      <= ST_IDLE;
         bit_cnt    <= 4'h0;
         shreg      <= 8'h00;
         ptr        <= 8'h00;
         first      <= 1'b0;
         rw         <= 1'b0;
         sda_oe_out <= 1'b0;
         wr_stb_out <= 1'b0;
         wr_addr_out <= 8'h00;
         wr_data_out <= 8'h00;
      end else begin
         wr_stb_out <= 1'b0;
         if (start_det) begin
            state      <= ST_ADDR;
            bit_cnt    <= 4'h0;
            first      <= 1'b1;
            sda_oe_out <= 1'b0;
         end else if (stop_det) begin
            state      <= ST_IDLE;
            sda_oe_out <= 1'b0;
         end else if (load_now) begin
            // open drain: a one is sent by releasing the line
            shreg      <= rd_data_in;
            sda_oe_out <= ~rd_data_in[7];
            ptr        <= ptr + 8'h01;
            bit_cnt    <= 4'h0;
            state      <= ST_RDATA;
         end else if (scl_rise) begin
            case (state)
               ST_ADDR, ST_WDATA: begin
                  shreg   <= {shreg[6:0], sda_q[1]};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               ST_RDATA: bit_cnt <= bit_cnt + 4'h1;
               ST_RACK: if (sda_q[1]) begin
                  state <= ST_IDLE;
               end
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state)
               ST_ADDR: if (byte_done) begin
                  if (addr_hit) begin
                     sda_oe_out <= 1'b1;
                     rw         <= shreg[0];
                     state      <= ST_ADDR_ACK;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
               ST_ADDR_ACK: begin
                  sda_oe_out <= 1'b0;
                  bit_cnt    <= 4'h0;
                  state      <= ST_WDATA;
               end
               ST_WDATA: if (byte_done) begin
                  sda_oe_out <= 1'b1;
                  state      <= ST_WACK;
                  if (first) begin
                     ptr   <= shreg;
                     first <= 1'b0;
                  end else begin
                     wr_stb_out  <= 1'b1;
                     wr_addr_out <= ptr;
                     wr_data_out <= shreg;
                     ptr         <= ptr + 8'h01;
                  end
               end
               ST_WACK: begin
                  sda_oe_out <= 1'b0;
                  bit_cnt    <= 4'h0;
                  state      <= ST_WDATA;
               end
               ST_RDATA: begin
                  shreg <= {shreg[6:0], 1'b0};
                  if (byte_done) begin
                     sda_oe_out <= 1'b0;
                     state      <= ST_RACK;
                  end else begin
                     sda_oe_out <= ~shreg[6];
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule // blcfr_i2c_slave

// file: design/blcfr_top.sv
// Purpose: second function-set register and fault register of a
//          six-string backlight driver, reached over the serial link
// Assumes: fault and pin inputs are asynchronous to clk_in
// Notes:   fault flags clear only by reset, except over-temperature
//
// Behaviour
// - phase offset bit 7 of 0x01 staggers strings; zero, default, in phase
// - bits 6:5 pick short threshold 2.5/5/7.5/10 V, reset code 01
// - bits 4:3 pick 200k/400k/1M/2.2MHz switching, reset code 01
// - bits 2:0 drop top strings: 000 all six, 101 only string one
// - bit 7 of 0x02 enables all-strings-short guard, reset off
// - bit 6 of 0x02 set shuts the device down, reset enabled
// - ground short flag, bit 5, sets and holds until power reset
// - over-temperature flag, bit 4, holds until read or reset
// - reading clears over-temperature flag only once the fault is gone
// - under-voltage flag, bit 3, holds until power reset
// - over-current flag, bit 2, holds until power reset
// - register threshold applies only while threshold pin floats
// - guard on: all strings over threshold 480 ms marks off, standby
`timescale 1ns/10ps
module blcfr_top
   import blcfr_pkg::*;
#(
   parameter int unsigned GUARD_CYCLES = GUARD_CYCLES_DEF
) (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       ground_short_in,
   input  wire logic       over_temp_in,
   input  wire logic       undervolt_in,
   input  wire logic       over_current_in,
   input  wire logic       all_over_threshold_in,
   input  wire logic       thr_pin_floating_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            phase_offset_enable_out,
   output logic [1:0]      short_threshold_select_out,
   output logic            threshold_from_register_out,
   output logic [1:0]      switch_freq_select_out,
   output logic [5:0]      string_enable_out,
   output logic            strings_marked_off_out,
   output logic            standby_out,
   output logic            device_enable_out
);
   logic [7:0]  fset2;
   logic        guard_en;
   logic        shutdown;
   logic        flag_g;
   logic        flag_ot;
   logic        flag_uv;
   logic        flag_oc;
   logic [5:0]  sync_a;
   logic [5:0]  sync_b;
   logic [31:0] guard_cnt;
   logic        tripped;
   logic        wr_stb;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        rd_stb;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data;

   blcfr_i2c_slave u_link (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .rd_data_in  (rd_data),
      .sda_oe_out  (sda_oe_out),
      .wr_stb_out  (wr_stb),
      .wr_addr_out (wr_addr),
      .wr_data_out (wr_data),
      .rd_stb_out  (rd_stb),
      .rd_addr_out (rd_addr)
   );

   // synchronised pins: sync_a only feeds sync_b
   wire g_s     = sync_b[0];
   wire ot_s    = sync_b[1];
   wire uv_s    = sync_b[2];
   wire oc_s    = sync_b[3];
   wire all_s   = sync_b[4];
   wire float_s = sync_b[5];

   wire wr_fset2 = wr_stb & (wr_addr == ADDR_FSET2);
   wire wr_fault = wr_stb & (wr_addr == ADDR_FAULT);
   wire rd_fault = rd_stb & (rd_addr == ADDR_FAULT);
   wire [7:0] fault_val = {guard_en, shutdown, flag_g, flag_ot,
                           flag_uv, flag_oc, 2'h0};
   // unmapped and out-of-scope addresses read as zero
   assign rd_data = (rd_addr == ADDR_FSET2) ? fset2 :
                    (rd_addr == ADDR_FAULT) ? fault_val : 8'h00;
   // set wins over the read clear; a live fault keeps the flag
   wire next_ot = ot_s | (flag_ot & ~rd_fault);
   wire guard_arm = guard_en & all_s;
   wire guard_hit = (guard_cnt == GUARD_CYCLES - 32'h1);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         sync_a <= 6'h00;
         sync_b <= 6'h00;
      end else begin
         sync_a <= {thr_pin_floating_in, all_over_threshold_in,
                    over_current_in, undervolt_in, over_temp_in,
                    ground_short_in};
         sync_b <= sync_a;
      end
   end

   // shutdown never touches the settings, so re-enable needs no rewrite
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         fset2    <= FSET2_RST;
         guard_en <= CTRL_RST[1];
         shutdown <= CTRL_RST[0];
      end else begin
         if (wr_fset2) begin
            fset2 <= wr_data;
         end
         if (wr_fault) begin
            // only the two control bits take write data
            guard_en <= wr_data[GUARD_BIT];
            shutdown <= wr_data[SHUT_BIT];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         flag_g  <= 1'b0;
         flag_ot <= 1'b0;
         flag_uv <= 1'b0;
         flag_oc <= 1'b0;
      end else begin
         flag_g  <= flag_g | g_s;
         flag_ot <= next_ot;
         flag_uv <= flag_uv | uv_s;
         flag_oc <= flag_oc | oc_s;
      end
   end

   // the 480 ms window restarts whenever the condition drops
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         guard_cnt <= 32'h0;
         tripped   <= 1'b0;
      end else if (!guard_arm) begin
         guard_cnt <= 32'h0;
         tripped   <= 1'b0;
      end else if (guard_hit) begin
         tripped <= 1'b1;
      end else if (!tripped) begin
         guard_cnt <= guard_cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         sda_out                     <= 1'b0;
         phase_offset_enable_out     <= 1'b0;
         short_threshold_select_out  <= 2'h0;
         threshold_from_register_out <= 1'b0;
         switch_freq_select_out      <= 2'h0;
         string_enable_out           <= 6'h00;
         strings_marked_off_out      <= 1'b0;
         standby_out                 <= 1'b0;
         device_enable_out           <= 1'b0;
      end else begin
         sda_out                     <= 1'b0;
         phase_offset_enable_out     <= fset2[PHASE_BIT];
         short_threshold_select_out  <= fset2[THR_HI:THR_LO];
         threshold_from_register_out <= float_s;
         switch_freq_select_out      <= fset2[FREQ_HI:FREQ_LO];
         // reserved codes shift out every string
         string_enable_out <= ALL_STRINGS >> fset2[CNT_HI:0];
         strings_marked_off_out <= tripped;
         standby_out            <= tripped | shutdown;
         device_enable_out      <= ~shutdown;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   chk_ground_sticky: assert property (flag_g |=> flag_g)
      else $error("ground short flag dropped");
   chk_uv_sticky: assert property (flag_uv |=> flag_uv)
      else $error("under-voltage flag dropped");
   chk_oc_sticky: assert property (flag_oc |=> flag_oc)
      else $error("over-current flag dropped");
   chk_ot_live_hold: assert property (flag_ot && ot_s |=> flag_ot)
      else $error("over-temperature flag cleared while fault live");
   chk_ot_read_clear: assert property (
      rd_fault && !ot_s |=> !flag_ot)
      else $error("over-temperature flag not cleared by read");
   chk_flag_write_ign: assert property (
      wr_fault && !g_s && !flag_g |=> !flag_g)
      else $error("write changed a fault flag");
   chk_freq_follow: assert property (
      wr_fset2 |-> ##2
         switch_freq_select_out == $past(wr_data[FREQ_HI:FREQ_LO], 2))
      else $error("frequency select not following write");
   chk_string_map: assert property (
      wr_fset2 && wr_data[2:0] == 3'h3 |-> ##2 string_enable_out == 6'h07)
      else $error("string mask wrong for code 3");
   chk_shutdown_out: assert property (
      wr_fault && wr_data[SHUT_BIT] |-> ##2 !device_enable_out && standby_out)
      else $error("shutdown did not disable device");
   chk_guard_trip: assert property (
      guard_arm && guard_hit |=> ##1 strings_marked_off_out && standby_out)
      else $error("guard did not trip at window end");
endmodule // blcfr_top

// file: pkg/blcfr_pkg.sv
// Purpose: shared constants for the backlight config and fault registers
// Assumes: 200 MHz core clock, serial link sampled by that clock
// Notes:   register map, field positions, reset values, link states
package blcfr_pkg;
   localparam logic [6:0] DEV_ADDR     = 7'h38;
   localparam logic [7:0] ADDR_FSET2   = 8'h01;
   localparam logic [7:0] ADDR_FAULT   = 8'h02;
   localparam logic [7:0] FSET2_RST    = 8'h28;
   localparam logic [1:0] CTRL_RST     = 2'h0;
   localparam int         PHASE_BIT    = 7;
   localparam int         THR_HI       = 6;
   localparam int         THR_LO       = 5;
   localparam int         FREQ_HI      = 4;
   localparam int         FREQ_LO      = 3;
   localparam int         CNT_HI       = 2;
   localparam int         GUARD_BIT    = 7;
   localparam int         SHUT_BIT     = 6;
   localparam logic [5:0] ALL_STRINGS  = 6'h3f;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int unsigned CLK_MHZ       = 200;
   localparam int unsigned GUARD_TIME_MS = 480;
   localparam int unsigned GUARD_CYCLES_DEF = GUARD_TIME_MS * CLK_MHZ * 1000;
   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_ADDR     = 7'h02,
      ST_ADDR_ACK = 7'h04,
      ST_WDATA    = 7'h08,
      ST_WACK     = 7'h10,
      ST_RDATA    = 7'h20,
      ST_RACK     = 7'h40
   } blcfr_state_t;
endpackage

// file: tb/blcfr_host.sv
// Purpose: serial host model that configures and polls the driver
// Assumes: data line has a pull-up, host owns the link clock
// Notes:   clock stands high between frames; stretch slows the low phase
`timescale 1ns/10ps
module blcfr_host
   import blcfr_pkg::*;
(
   input  wire logic sda_oe_in,
   output logic      scl_out,
   output logic      sda_wire_out
);
   logic sda_drv = 1'b1;
   int   stretch = 0;
   initial scl_out = 1'b1;
   // released line floats high through the pull-up
   assign sda_wire_out = sda_drv & ~sda_oe_in;
   // threshold pin is never driven by this host
   // data moves late in the low phase, after the slave lets go
   task automatic bit_io(input logic b, output logic r);
      #(31 + stretch) sda_drv = b;
      #5 scl_out = 1'b1;
      #8 r = sda_wire_out;
      #4 scl_out = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic m_ack,
                          output logic [7:0] r, output logic s_ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(m_ack, b);
      s_ack = ~b;
   endtask
   task automatic start;
      #31 sda_drv = 1'b1;
      #17 scl_out = 1'b1;
      #24 sda_drv = 1'b0;
      #24 scl_out = 1'b0;
   endtask
   task automatic stop;
      #31 sda_drv = 1'b0;
      #17 scl_out = 1'b1;
      #24 sda_drv = 1'b1;
      #24;
   endtask
   task automatic probe(input logic [6:0] dev, output logic ok);
      logic [7:0] x;
      start();
      byte_io({dev, 1'b0}, 1'b1, x, ok);
      stop();
   endtask
   task automatic wr(input logic [7:0] a, d, output logic ok);
      logic [7:0] x;
      logic       k0, k1, k2;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, x, k0);
      byte_io(a, 1'b1, x, k1);
      byte_io(d, 1'b1, x, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q,
                     output logic ok);
      logic [7:0] x;
      logic       k0, k1, k2, n;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, x, k0);
      byte_io(a, 1'b1, x, k1);
      start();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, x, k2);
      byte_io(8'hff, 1'b1, q, n);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule // blcfr_host

// file: tb/tb_blcfr_top.sv
// Purpose: self-checking bench for the config and fault registers
// Assumes: guard time shortened to GC cycles
// Notes:   all register traffic goes through the host model
`timescale 1ns/10ps
module tb_blcfr_top;
   import blcfr_pkg::*;
   localparam int GC = 50;
   logic       clk_in = 1'b0;
   logic       rstn_in = 1'b0;
   logic       g_in = 0, ot_in = 0, uv_in = 0, oc_in = 0, ao_in = 0;
   logic       fl_in = 1'b1;
   logic       scl, sda, sda_drv, sda_oe, phase, thr_reg;
   logic       marked, standby, dev_en, ok;
   logic [1:0] thr, freq;
   logic [5:0] str_en;
   logic [7:0] q, d;
   int         n_errors = 0;
   int         num_checks = 0;

   initial forever #2.5 clk_in = ~clk_in;

   blcfr_top #(.GUARD_CYCLES(GC)) u_dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
      .ground_short_in(g_in), .over_temp_in(ot_in), .undervolt_in(uv_in),
      .over_current_in(oc_in), .all_over_threshold_in(ao_in),
      .thr_pin_floating_in(fl_in), .sda_out(sda_drv), .sda_oe_out(sda_oe),
      .phase_offset_enable_out(phase), .short_threshold_select_out(thr),
      .threshold_from_register_out(thr_reg), .switch_freq_select_out(freq),
      .string_enable_out(str_en), .strings_marked_off_out(marked),
      .standby_out(standby), .device_enable_out(dev_en));

   blcfr_host u_host (.sda_oe_in(sda_oe), .scl_out(scl), .sda_wire_out(sda));

   task automatic check(input string nm, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, v);
      u_host.wr(a, v, ok);
      check("write ack", ok, 8'h1);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      u_host.rd(a, q, ok);
      check("read ack", ok, 8'h1);
      check("read data", q, exp);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [7:0] exp_str(input logic [2:0] c);
      return {2'b00, ALL_STRINGS >> c};
   endfunction

   initial begin
      #400us;
      n_errors++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      void'($urandom(32'h802a));
      wait_clk(2);
      rstn_in = 1'b1;
      wait_clk(6);
      check("cfg", {phase, thr, freq, 3'h0}, FSET2_RST);
      check("strings", {2'b00, str_en}, 8'h3f);
      check("ctl", {dev_en, standby, marked}, 8'h4);
      check("sda drive", {7'h0, sda_drv}, 8'h00);
      rd(ADDR_FSET2, FSET2_RST);
      rd(ADDR_FAULT, 8'h00);
      $display("done reset values");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[6:5] = 2'(i);
         d[4:3] = 2'(i >> 1);
         d[2:0] = 3'(i % 6); // codes 110 and 111 stay unwritten
         fl_in = 1'($urandom);
         u_host.stretch = (i == 3) ? 150 : 0;
         wr(ADDR_FSET2, d);
         wait_clk(4);
         check("cfg", {phase, thr, freq, 3'h0}, {d[7:3], 3'h0});
         check("strings", {2'b00, str_en}, exp_str(d[2:0]));
         check("thr src", {7'h0, thr_reg}, {7'h0, fl_in});
         rd(ADDR_FSET2, d);
      end
      u_host.stretch = 0;
      $display("done config");
      wr(ADDR_FAULT, 8'h7f);
      wait_clk(4);
      check("shut", {dev_en, standby}, 8'h1);
      rd(ADDR_FAULT, 8'h40);
      rd(ADDR_FSET2, d);
      wr(ADDR_FAULT, 8'h00);
      wait_clk(4);
      check("wake", {dev_en, standby}, 8'h2);
      wr(8'h03, 8'h5a);
      rd(8'h03, 8'h00);
      u_host.probe(7'h39, ok);
      check("foreign addr", ok, 8'h0);
      $display("done shutdown");
      {g_in, uv_in, oc_in, ot_in} = 4'hf;
      wait_clk(3 + $urandom_range(7));
      {g_in, uv_in, oc_in, ot_in} = 4'h0;
      wait_clk(4);
      rd(ADDR_FAULT, 8'h3c);
      rd(ADDR_FAULT, 8'h2c);
      ot_in = 1'b1;
      wait_clk(4);
      rd(ADDR_FAULT, 8'h3c);
      rd(ADDR_FAULT, 8'h3c);
      ot_in = 1'b0;
      wait_clk(4);
      rd(ADDR_FAULT, 8'h3c);
      rd(ADDR_FAULT, 8'h2c);
      wr(ADDR_FAULT, 8'h00);
      rd(ADDR_FAULT, 8'h2c);
      $display("done faults");
      wr(ADDR_FAULT, 8'h80);
      ao_in = 1'b1;
      wait_clk(GC - 10);
      check("early", {marked, standby}, 8'h0);
      ao_in = 1'b0;
      wait_clk(4);
      ao_in = 1'b1;
      wait_clk(GC + 8);
      check("tripped", {marked, standby}, 8'h3);
      ao_in = 1'b0;
      wait_clk(4);
      check("released", {marked, standby}, 8'h0);
      wr(ADDR_FAULT, 8'h00);
      ao_in = 1'b1;
      wait_clk(GC + 10);
      check("guard off", {marked, standby}, 8'h0);
      ao_in = 1'b0;
      $display("done guard");
      rstn_in = 1'b0;
      wait_clk(3);
      rstn_in = 1'b1;
      wait_clk(6);
      rd(ADDR_FSET2, FSET2_RST);
      rd(ADDR_FAULT, 8'h00);
      check("sda drive", {7'h0, sda_drv}, 8'h00);
      $display("done second reset");
      summarize();
   end
endmodule // tb_blcfr_top
